/* design/eeac_pkg.sv */
// Shared constants and types for the data EEPROM access control block.
// Assumes one system clock and a synchronous active-high reset.
package eeac_pkg;

  // Widths of the address, data, control and mode fields
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CTRL_W = 8;
  localparam int PM_W   = 2;
  localparam int CNT_W  = 3;

  // Control register bit positions
  localparam int RS_BIT  = 0;
  localparam int WS_BIT  = 1;
  localparam int MWE_BIT = 2;
  localparam int PM_LSB  = 4;

  // Cycle counts: arming window and CPU halt lengths
  localparam logic [CNT_W-1:0] ARM_CYCLES = 3'h4;
  localparam logic [CNT_W-1:0] WR_STALL   = 3'h2;
  localparam logic [CNT_W-1:0] RD_STALL   = 3'h4;
  localparam logic [CNT_W-1:0] CNT_RST    = 3'h0;

  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [PM_W-1:0]   PM_RST   = 2'h0;

  // Access sequencer states, Gray along idle-read only; idle-program flips both bits
  typedef enum logic [1:0] {
    EEAC_IDLE = 2'h0,
    EEAC_READ = 2'h1,
    EEAC_PROG = 2'h3
  } eeac_state_t;

  // Registered state of the controller outside its two timers
  typedef struct packed {
    eeac_state_t       state;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [PM_W-1:0]   pm;
  } eeac_regs_t;

  // Timer state
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } eeac_tmr_t;

endpackage : eeac_pkg

/* design/eeac_tmr_if.sv */
// Load and status signals between the controller and one down-counter.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface eeac_tmr_if;
  logic                       load;
  logic [eeac_pkg::CNT_W-1:0] load_val;
  logic                       active;

  modport owner (output load, output load_val, input active);
  modport timer (input load, input load_val, output active);
endinterface : eeac_tmr_if
`default_nettype wire

/* design/eeac_timer.sv */
// Small down-counter: active for load_val cycles after a load pulse.
// Assumes load comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module eeac_timer (
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   rst,
  // Load and status
  eeac_tmr_if.timer   tif
);

  eeac_pkg::eeac_tmr_t s_q;
  eeac_pkg::eeac_tmr_t s_d;

  // Reload wins over counting so a re-arm restarts the window
  always_comb begin
    s_d = s_q;
    if (tif.load) begin
      s_d.cnt = tif.load_val;
    end else if (s_q.cnt != eeac_pkg::CNT_RST) begin
      s_d.cnt = s_q.cnt - 3'h1;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q.cnt <= eeac_pkg::CNT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign tif.active = (s_q.cnt != eeac_pkg::CNT_RST);

endmodule : eeac_timer
`default_nettype wire

/* design/eeac_ctrl.sv */
// Data EEPROM access control: arming, write busy, read strobe, CPU halt.
// Assumes CPU register strobes and the EEPROM array share mclk; the
// array returns read data one cycle after its read enable and raises
// a done pulse when its programming time has elapsed.
//
// How it works
// - Strobe inside four-cycle arming window starts programming
// - Strobe without arming is ignored
// - Arming bit self-clears four cycles after set
// - Programming uses the selected mode field
// - Busy bit holds until programming time elapses
// - Write trigger halts CPU two cycles
// - Address first, then read strobe reads byte
// - Read byte lands in data register at the second edge after the read strobe
// - Read trigger halts CPU four cycles
// - Busy write blocks reads and address changes
`timescale 1ns/1ps
`default_nettype none
module eeac_ctrl (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // CPU register writes
  input  wire logic                        ctrl_wr,
  input  wire logic [eeac_pkg::CTRL_W-1:0] ctrl_wdata,
  input  wire logic                        addr_wr,
  input  wire logic [eeac_pkg::ADDR_W-1:0] addr_wdata,
  input  wire logic                        data_wr,
  input  wire logic [eeac_pkg::DATA_W-1:0] data_wdata,
  // CPU register reads and halt
  output logic      [eeac_pkg::CTRL_W-1:0] ctrl_rdata,
  output logic      [eeac_pkg::ADDR_W-1:0] addr_rdata,
  output logic      [eeac_pkg::DATA_W-1:0] data_rdata,
  output logic                             cpu_stall,
  // EEPROM array side
  output logic      [eeac_pkg::ADDR_W-1:0] ee_addr,
  output logic                             ee_rd_en,
  input  wire logic [eeac_pkg::DATA_W-1:0] ee_rd_data,
  output logic                             ee_prog_start,
  output logic      [eeac_pkg::PM_W-1:0]   ee_prog_mode,
  output logic      [eeac_pkg::DATA_W-1:0] ee_wr_data,
  input  wire logic                        ee_prog_done
);

  // Pick one control bit out of a written byte
  function automatic logic ctrl_bit(
    input logic [eeac_pkg::CTRL_W-1:0] v,
    input int                          pos
  );
    ctrl_bit = v[pos];
  endfunction : ctrl_bit

  eeac_pkg::eeac_regs_t r_q;
  eeac_pkg::eeac_regs_t r_d;

  eeac_tmr_if arm_if ();
  eeac_tmr_if stall_if ();

  logic wr_mwe;
  logic wr_ws;
  logic wr_rs;
  logic armed;
  logic busy;
  logic idle;

  // Decoded write intents
  assign wr_mwe = ctrl_wr && ctrl_bit(ctrl_wdata, eeac_pkg::MWE_BIT);
  assign wr_ws  = ctrl_wr && ctrl_bit(ctrl_wdata, eeac_pkg::WS_BIT);
  assign wr_rs  = ctrl_wr && ctrl_bit(ctrl_wdata, eeac_pkg::RS_BIT);
  assign armed  = arm_if.active;
  assign busy   = (r_q.state == eeac_pkg::EEAC_PROG);
  assign idle   = (r_q.state == eeac_pkg::EEAC_IDLE);

  // Arming window: only the value armed before this write counts,
  // so setting both bits in one write does not start programming
  assign arm_if.load     = wr_mwe;
  assign arm_if.load_val = eeac_pkg::ARM_CYCLES;

  // Triggers; a read during programming is dropped, not queued
  assign ee_prog_start = wr_ws && armed && idle;
  assign ee_rd_en      = wr_rs && idle;

  // Halt length depends on which access was triggered
  assign stall_if.load     = ee_prog_start || ee_rd_en;
  assign stall_if.load_val = ee_prog_start ? eeac_pkg::WR_STALL
                                           : eeac_pkg::RD_STALL;
  assign cpu_stall = stall_if.active;

  eeac_timer u_arm (
    .mclk (mclk),
    .rst  (rst),
    .tif  (arm_if.timer)
  );

  eeac_timer u_stall (
    .mclk (mclk),
    .rst  (rst),
    .tif  (stall_if.timer)
  );

  // Next-state logic of the access sequencer and its registers
  always_comb begin
    r_d = r_q;
    unique case (r_q.state)
      eeac_pkg::EEAC_IDLE: begin
        if (ee_prog_start) begin
          r_d.state = eeac_pkg::EEAC_PROG;
        end else if (ee_rd_en) begin
          r_d.state = eeac_pkg::EEAC_READ;
        end
      end
      eeac_pkg::EEAC_READ: begin
        r_d.data  = ee_rd_data;
        r_d.state = eeac_pkg::EEAC_IDLE;
      end
      eeac_pkg::EEAC_PROG: begin
        if (ee_prog_done) begin
          r_d.state = eeac_pkg::EEAC_IDLE;
        end
      end
      default: begin
        r_d.state = eeac_pkg::EEAC_IDLE;
      end
    endcase
    // Address and mode are frozen while the array is programming
    if (addr_wr && !busy) begin
      r_d.addr = addr_wdata;
    end
    if (ctrl_wr && !busy) begin
      r_d.pm = ctrl_wdata[eeac_pkg::PM_LSB +: eeac_pkg::PM_W];
    end
    // Data byte is kept stable for the array during programming
    if (data_wr && !busy &&
        (r_q.state != eeac_pkg::EEAC_READ)) begin
      r_d.data = data_wdata;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      r_q.state <= eeac_pkg::EEAC_IDLE;
      r_q.addr  <= eeac_pkg::ADDR_RST;
      r_q.data  <= eeac_pkg::DATA_RST;
      r_q.pm    <= eeac_pkg::PM_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // Readback; the read strobe always reads zero
  always_comb begin
    ctrl_rdata = '0;
    ctrl_rdata[eeac_pkg::PM_LSB +: eeac_pkg::PM_W] = r_q.pm;
    ctrl_rdata[eeac_pkg::MWE_BIT] = armed;
    ctrl_rdata[eeac_pkg::WS_BIT]  = busy;
  end

  // Array and CPU data outputs straight from registers
  assign addr_rdata   = r_q.addr;
  assign data_rdata   = r_q.data;
  assign ee_addr      = r_q.addr;
  assign ee_prog_mode = r_q.pm;
  assign ee_wr_data   = r_q.data;

  // Checks on the arming window
  a_arm_held: assert property (@(posedge mclk) disable iff (rst)
    wr_mwe |=> armed [*4])
    else $error("arming bit dropped inside its window");

  a_arm_clears: assert property (@(posedge mclk) disable iff (rst)
    wr_mwe ##1 (!wr_mwe) [*4] |=> !armed)
    else $error("arming bit did not self-clear");

  a_armed_start: assert property (@(posedge mclk) disable iff (rst)
    (wr_ws && armed && idle) |-> ee_prog_start ##1 busy)
    else $error("armed strobe did not start programming");

  a_unarmed_drop: assert property (@(posedge mclk) disable iff (rst)
    (wr_ws && !armed && idle && !wr_rs) |=> idle)
    else $error("unarmed strobe started programming");

  // Checks on programming
  a_mode_stable: assert property (@(posedge mclk) disable iff (rst)
    (busy && $past(busy)) |-> $stable(ee_prog_mode))
    else $error("program mode changed during programming");

  a_busy_held: assert property (@(posedge mclk) disable iff (rst)
    (busy && !ee_prog_done) |=> ctrl_rdata[eeac_pkg::WS_BIT])
    else $error("busy bit cleared before done");

  a_busy_ends: assert property (@(posedge mclk) disable iff (rst)
    (busy && ee_prog_done) |=> !ctrl_rdata[eeac_pkg::WS_BIT])
    else $error("busy bit stuck after done");

  a_busy_reads: assert property (@(posedge mclk) disable iff (rst)
    ee_prog_start |=> ctrl_rdata[eeac_pkg::WS_BIT])
    else $error("busy bit not shown after start");

  a_wr_stall: assert property (@(posedge mclk) disable iff (rst)
    ee_prog_start |=> cpu_stall [*2] ##1 !cpu_stall)
    else $error("write halt is not two cycles");

  // Checks on reads and blocking
  a_rd_stall: assert property (@(posedge mclk) disable iff (rst)
    ee_rd_en |=> cpu_stall [*4] ##1 !cpu_stall)
    else $error("read halt is not four cycles");

  a_rd_data: assert property (@(posedge mclk) disable iff (rst)
    ee_rd_en ##1 (!data_wr) |=> data_rdata == $past(ee_rd_data))
    else $error("read byte not captured");

  a_rd_blocked: assert property (@(posedge mclk) disable iff (rst)
    busy |-> !ee_rd_en)
    else $error("read issued during programming");

  a_addr_frozen: assert property (@(posedge mclk) disable iff (rst)
    (busy && addr_wr) |=> $stable(addr_rdata))
    else $error("address changed during programming");

endmodule : eeac_ctrl
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the data EEPROM access control block.
// Assumes eeac_ctrl and its package, timer and interface are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Clock, reset and port nets
  logic                        mclk, rst;
  logic                        ctrl_wr, addr_wr, data_wr, ee_rd_en;
  logic [eeac_pkg::CTRL_W-1:0] ctrl_wdata, ctrl_rdata;
  logic [eeac_pkg::ADDR_W-1:0] addr_wdata, addr_rdata, ee_addr;
  logic [eeac_pkg::DATA_W-1:0] data_wdata, data_rdata, ee_rd_data, ee_wr_data;
  logic [eeac_pkg::PM_W-1:0]   ee_prog_mode;
  logic                        cpu_stall, ee_prog_start, ee_prog_done;
  int                          n_mismatch, tests_run, cyc;

  eeac_ctrl eeac_ctrl_inst (
    .mclk(mclk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .addr_wr(addr_wr), .addr_wdata(addr_wdata), .data_wr(data_wr),
    .data_wdata(data_wdata), .ctrl_rdata(ctrl_rdata),
    .addr_rdata(addr_rdata), .data_rdata(data_rdata),
    .cpu_stall(cpu_stall), .ee_addr(ee_addr), .ee_rd_en(ee_rd_en),
    .ee_rd_data(ee_rd_data), .ee_prog_start(ee_prog_start),
    .ee_prog_mode(ee_prog_mode), .ee_wr_data(ee_wr_data),
    .ee_prog_done(ee_prog_done));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Control byte with one strobe bit and a mode field
  function automatic logic [7:0] cb(input int pos, input logic [1:0] m);
    return (8'h01 << pos) | (8'(m) << eeac_pkg::PM_LSB);
  endfunction : cb

  // One control write; comb pulses sampled mid cycle 0, returns at cycle 1
  task automatic ctrl_op(input logic [7:0] v, output logic ps, re);
    @(posedge mclk);
    ctrl_wr    <= 1'h1;
    ctrl_wdata <= v;
    @(negedge mclk);
    ps = ee_prog_start;
    re = ee_rd_en;
    @(posedge mclk);
    ctrl_wr <= 1'h0;
  endtask : ctrl_op

  task automatic reg_op(input logic is_data, input logic [7:0] v);
    @(posedge mclk);
    if (is_data) begin
      data_wr    <= 1'h1;
      data_wdata <= v;
    end else begin
      addr_wr    <= 1'h1;
      addr_wdata <= v[6:0];
    end
    @(posedge mclk);
    addr_wr <= 1'h0;
    data_wr <= 1'h0;
  endtask : reg_op

  // Stall expected in the first n of span cycles
  task automatic stall_chk(input int n, input int span);
    for (int i = 1; i <= span; i++) begin
      @(negedge mclk);
      chk("cpu_stall", cpu_stall, 8'(i <= n));
    end
  endtask : stall_chk

  // Unarmed strobes, window length and a late strobe
  task automatic t_arm_window();
    logic ps, re;
    ctrl_op(cb(eeac_pkg::WS_BIT, 2'h0), ps, re);
    chk("start_unarmed", ps, 8'h0);
    ctrl_op(cb(eeac_pkg::WS_BIT, 2'h0) | cb(eeac_pkg::MWE_BIT, 2'h0), ps, re);
    chk("start_same_write", ps, 8'h0);
    for (int i = 1; i <= 5; i++) begin
      @(negedge mclk);
      chk("armed", ctrl_rdata[eeac_pkg::MWE_BIT], 8'(i <= 4));
    end
    ctrl_op(cb(eeac_pkg::WS_BIT, 2'h0), ps, re);
    chk("start_late", ps, 8'h0);
    @(negedge mclk);
    chk("busy_idle", ctrl_rdata[eeac_pkg::WS_BIT], 8'h0);
  endtask : t_arm_window

  // Armed program in mode m, with blocked traffic while busy;
  // gap 2 puts the strobe in the last armed cycle of the window
  task automatic t_write(input logic [1:0] m, input logic [7:0] a, d,
                         input int gap);
    logic ps, re;
    reg_op(1'b0, a);
    reg_op(1'b1, d);
    ctrl_op(cb(eeac_pkg::MWE_BIT, m), ps, re);
    repeat (gap) @(posedge mclk);
    ctrl_op(cb(eeac_pkg::WS_BIT, m), ps, re);
    chk("prog_start", ps, 8'h1);
    stall_chk(2, 3);
    chk("busy", ctrl_rdata[eeac_pkg::WS_BIT], 8'h1);
    chk("prog_mode", ee_prog_mode, 8'(m));
    chk("mode_read", ctrl_rdata[5:4], 8'(m));
    chk("prog_addr", ee_addr, a & 8'h7F);
    chk("prog_data", ee_wr_data, d);
    ctrl_op(cb(eeac_pkg::RS_BIT, 2'h0), ps, re);
    chk("rd_while_busy", re, 8'h0);
    reg_op(1'b0, ~a);
    @(negedge mclk);
    chk("addr_while_busy", addr_rdata, a & 8'h7F);
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    chk("busy_held", ctrl_rdata[eeac_pkg::WS_BIT], 8'h1);
    @(posedge mclk);
    ee_prog_done <= 1'h1;
    @(posedge mclk);
    ee_prog_done <= 1'h0;
    @(negedge mclk);
    chk("busy_cleared", ctrl_rdata[eeac_pkg::WS_BIT], 8'h0);
  endtask : t_write

  // Read; the array byte is valid only in cycle 1 to catch a wrong sample
  task automatic t_read(input logic [7:0] a, v);
    logic ps, re;
    for (int k = 0; k < 50 && ctrl_rdata[eeac_pkg::WS_BIT] !== 1'b0; k++)
      @(posedge mclk);
    reg_op(1'b0, a);
    ee_rd_data <= ~v;
    // Address register settles after the edge that takes the write
    @(negedge mclk);
    chk("rd_addr", ee_addr, a & 8'h7F);
    ctrl_op(cb(eeac_pkg::RS_BIT, 2'h0), ps, re);
    ee_rd_data <= v;
    chk("rd_en", re, 8'h1);
    @(negedge mclk);
    chk("cpu_stall", cpu_stall, 8'h1);
    @(posedge mclk);
    ee_rd_data <= ~v;
    stall_chk(3, 4);
    chk("rd_data", data_rdata, v);
  endtask : t_read

  // Reset in mid-program clears busy, window, halt and registers
  task automatic t_reset_mid();
    logic ps, re;
    reg_op(1'b0, 8'h33);
    ctrl_op(cb(eeac_pkg::MWE_BIT, 2'h2), ps, re);
    ctrl_op(cb(eeac_pkg::WS_BIT, 2'h2), ps, re);
    chk("rst_prog_start", ps, 8'h1);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk("ctrl_after_rst", ctrl_rdata, 8'h00);
    chk("addr_after_rst", addr_rdata, 8'h00);
    chk("stall_after_rst", cpu_stall, 8'h0);
  endtask : t_reset_mid

  // Main sequence
  initial begin
    {ctrl_wr, addr_wr, data_wr, ee_prog_done} = 4'h0;
    {ctrl_wdata, addr_wdata, data_wdata, ee_rd_data} = '0;
    {n_mismatch, tests_run} = '0;
    rst = 1'b1;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk("ctrl_reset", ctrl_rdata, 8'h00);
    chk("stall_reset", cpu_stall, 8'h0);
    t_arm_window();
    t_write(2'h0, 8'h00, 8'hA5, 0);
    t_write(2'h1, 8'h7F, 8'h5A, 0);
    t_write(2'h2, 8'h2A, 8'hFF, 1);
    t_write(2'h3, 8'h55, 8'h00, 2);
    t_reset_mid();
    t_read(8'h7F, 8'hC3);
    t_read(8'h01, 8'h3C);
    stop_test();
  end
endmodule : tb
`default_nettype wire
